/* hdl/eil_pkg.sv */
// Purpose: shared constants for the external interrupt input logic
// Assumes: fc equals hclk (100 MHz), so one fc period is one clock cycle
// Notes:   register indices are word indices; byte address = 4 * index
package eil_pkg;
    // ------------------------------------------------------------------
    // timing, in periods of fc
    // ------------------------------------------------------------------
    localparam int CLK_PER_FC = 1;
    localparam int FC_REJECT_AE = 2;
    localparam int FC_ACCEPT_AE = 7;
    localparam int FC_REJECT_BD = 7;
    localparam int FC_ACCEPT_BD = 25;
    localparam int FC_LATCH_MAX_BD = 31;
    // threshold sits midway between the reject and accept figures
    localparam int FILT_AE = (FC_REJECT_AE + FC_ACCEPT_AE) / 2 * CLK_PER_FC;
    localparam int FILT_BD = (FC_REJECT_BD + FC_ACCEPT_BD) / 2 * CLK_PER_FC;
    localparam int FILT_W = 5;
    // ------------------------------------------------------------------
    // sources
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 5;
    localparam int SRC_A = 0;
    localparam int SRC_B = 1;
    localparam int SRC_C = 2;
    localparam int SRC_D = 3;
    localparam int SRC_E = 4;
    // ------------------------------------------------------------------
    // register indices and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL = 8'h37;
    localparam logic [7:0] IDX_LATCH = 8'h38;
    localparam logic [7:0] IDX_ENABLE = 8'h39;
    localparam logic [7:0] IDX_MASTER = 8'h3A;
    localparam logic [7:0] IDX_PINS = 8'h3B;
    localparam logic [7:0] IDX_PORT5 = 8'h3C;
    localparam int CTRL_FIRST_SEL = 6;
    localparam int CTRL_FOURTH_ES = 4;
    localparam int CTRL_SECOND_ES = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int PORT5_DATA = 0;
    localparam int PORT5_DIR = 1;
    localparam int PINS_FILT_LSB = 8;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_BOTH = 2'b10
    } eil_edge_t;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ = 2'b10
    } eil_phase_t;
endpackage : eil_pkg

/* hdl/eil_noise_filter.sv */
// Purpose: digital noise rejection for one interrupt pin
// Assumes: pin_in is synchronous to hclk
// Notes:   output follows the pin once it has held a new level FILT_CYC cycles
`timescale 1ns/1ps
module eil_noise_filter import eil_pkg::*; #(
    parameter int FILT_CYC = FILT_AE,
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pin and result
    input wire logic pin_in,
    output logic level_out
);
    logic [FILT_W-1:0] cnt_ff;
    logic level_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
            level_ff <= RESET_LEVEL;
        end else if (pin_in == level_ff) begin
            cnt_ff <= '0;
        end else if (cnt_ff == FILT_W'(FILT_CYC - 1)) begin
            cnt_ff <= '0;
            level_ff <= pin_in;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign level_out = level_ff;
endmodule : eil_noise_filter

/* hdl/eil_edge_detect.sv */
// Purpose: selectable edge detection on a conditioned level
// Assumes: level changes at most once per cycle
// Notes:   suppress hides an edge seen while the selection is switching
`timescale 1ns/1ps
module eil_edge_detect import eil_pkg::*; #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire eil_edge_t edge_sel,
    input wire logic suppress,
    // level and result
    input wire logic level,
    output logic hit
);
    logic prev_ff;
    logic rise;
    logic fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_ff <= RESET_LEVEL;
        end else begin
            prev_ff <= level;
        end
    end

    assign rise = level & ~prev_ff;
    assign fall = ~level & prev_ff;

    always_comb begin
        case (edge_sel)
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_BOTH: hit = rise | fall;
            default: hit = 1'b0;
        endcase
        if (suppress) begin
            hit = 1'b0;
        end
    end
endmodule : eil_edge_detect

/* hdl/eil_ext_irq_ctrl.sv */
// Purpose: external interrupt input conditioning with an AHB-Lite register slave
// Assumes: pins synchronous to hclk; fc equals hclk; single word transfers
// Notes:   zero wait states; control register reads back as zero
//
// Function
// RULE_01: five external inputs; filtered ones drop pulses shorter than a set time.
// RULE_02: second, third, fourth have selectable edge; first and fifth falling only.
// RULE_03: reset leaves the shared first pin working as a port input.
// RULE_04: first-input latch never sets while its pin-function bit is zero.
// RULE_05: first request needs master enable, pin-function bit and its enable.
// RULE_06: first and fifth filters drop pulses under 2/fc, keep 7/fc or more.
// RULE_07: second and fourth filters drop pulses under 7/fc, keep 25/fc or more.
// RULE_08: clean edge on second or fourth sets its latch within 31/fc.
// RULE_09: the second input's filter also feeds the shared timer count input.
// RULE_10: driving a shared pin as output may raise false requests; software masks them.
// RULE_11: control register holds edge selects and first pin-function select.
// RULE_12: third input's edge setting comes from the remote-control preprocessor.
// RULE_13: control register at 37h, write-only, reset pattern 00*0 *00*.
// RULE_14: an edge seen while edge selection switches is discarded.
// RULE_15: software rewrites control only with master off, then clears latches.
// RULE_16: edge select bit 0 means rising, 1 means falling.
// RULE_17: software waits 8 machine cycles after an edge change before clearing.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module eil_ext_irq_ctrl import eil_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // interrupt pins
    input wire logic ext_irq_a,
    input wire logic ext_irq_b,
    input wire logic ext_irq_c,
    input wire logic ext_irq_d,
    input wire logic ext_irq_e,
    // remote-control preprocessor settings for the third input
    input wire logic [1:0] rc_edge_sel,
    // cpu acceptance clears the accepted latch
    input wire logic [NUM_SRC-1:0] irq_ack,
    // requests to the cpu
    output logic [NUM_SRC-1:0] irq_request,
    // shared pin as port bit
    output logic port5_bit0_out,
    output logic port5_bit0_oe,
    // filtered timer input
    output logic timer1_count_input
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    eil_phase_t phase_ff;
    logic [7:0] idx_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic [7:0] ctrl_ff;
    logic [NUM_SRC-1:0] latch_ff;
    logic [NUM_SRC-1:0] enable_ff;
    logic master_ff;
    logic [1:0] port5_ff;
    logic [NUM_SRC-1:0] irq_request_ff;
    logic timer1_ff;
    eil_edge_t sel_prev_ff [NUM_SRC];

    logic [NUM_SRC-1:0] pin_vec;
    logic [NUM_SRC-1:0] lvl;
    logic [NUM_SRC-1:0] hit;
    logic [NUM_SRC-1:0] suppress;
    logic [NUM_SRC-1:0] gate;
    eil_edge_t sel_w [NUM_SRC];
    logic [NUM_SRC-1:0] nxt_latch;
    logic [NUM_SRC-1:0] latch_clr;
    logic [NUM_SRC-1:0] nxt_irq_request;
    logic addr_ok;
    logic wr_data_phase;
    logic first_sel;
    logic [31:0] rd_mux;

    assign pin_vec = {ext_irq_e, ext_irq_d, ext_irq_c, ext_irq_b, ext_irq_a};
    assign first_sel = ctrl_ff[CTRL_FIRST_SEL];

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    assign addr_ok = hsel & htrans[1] & hready;
    assign wr_data_phase = (phase_ff == PH_WRITE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_ff <= PH_IDLE;
            idx_ff <= '0;
        end else if (addr_ok) begin
            phase_ff <= hwrite ? PH_WRITE : PH_READ;
            idx_ff <= haddr[9:2];
        end else begin
            phase_ff <= PH_IDLE;
        end
    end

    // control register reads as zero: it is write-only [RULE_13]
    always_comb begin
        case (haddr[9:2])
            IDX_LATCH: rd_mux = {27'h000_0000, latch_ff};
            IDX_ENABLE: rd_mux = {27'h000_0000, enable_ff};
            IDX_MASTER: rd_mux = {31'h0000_0000, master_ff};
            IDX_PINS: rd_mux = {19'h0_0000, lvl, 3'h0, pin_vec};
            IDX_PORT5: rd_mux = {30'h0000_0000, port5_ff};
            default: rd_mux = RDATA_ZERO;
        endcase
    end

    // read data is registered so it stands for the whole data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= RDATA_ZERO;
        end else if (addr_ok && !hwrite) begin
            hrdata_ff <= rd_mux;
        end
    end

    // no wait states and never an error response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b0;
            hresp_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    // resets with every defined bit zero, pin back to port use [RULE_13] [RULE_03]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_data_phase && idx_ff == IDX_CTRL) begin
            ctrl_ff <= hwdata[7:0]; // [RULE_11]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_ff <= '0;
        end else if (wr_data_phase && idx_ff == IDX_ENABLE) begin
            enable_ff <= hwdata[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            master_ff <= 1'b0;
        end else if (wr_data_phase && idx_ff == IDX_MASTER) begin
            master_ff <= hwdata[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port5_ff <= '0;
        end else if (wr_data_phase && idx_ff == IDX_PORT5) begin
            port5_ff <= hwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // edge selection
    // ------------------------------------------------------------------
    always_comb begin
        sel_w[SRC_A] = EDGE_FALL; // [RULE_02]
        sel_w[SRC_E] = EDGE_FALL; // [RULE_02]
        sel_w[SRC_B] = ctrl_ff[CTRL_SECOND_ES] ? EDGE_FALL : EDGE_RISE; // [RULE_16]
        sel_w[SRC_D] = ctrl_ff[CTRL_FOURTH_ES] ? EDGE_FALL : EDGE_RISE; // [RULE_16]
        sel_w[SRC_C] = eil_edge_t'(rc_edge_sel); // [RULE_12]
    end

    // ------------------------------------------------------------------
    // per-source conditioning
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        if (i == SRC_C) begin : g_pre
            // already conditioned by the preprocessor [RULE_12]
            assign lvl[i] = pin_vec[i];
        end else begin : g_filt
            eil_noise_filter #(
                .FILT_CYC((i == SRC_A || i == SRC_E) ? FILT_AE : FILT_BD), // [RULE_06] [RULE_07]
                .RESET_LEVEL(1'b1)
            ) u_filt (
                .hclk(hclk),
                .hresetn(hresetn),
                .pin_in(pin_vec[i]), // [RULE_01]
                .level_out(lvl[i])
            );
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sel_prev_ff[i] <= EDGE_RISE;
            end else begin
                sel_prev_ff[i] <= sel_w[i];
            end
        end

        // a selection that changed this cycle hides any edge [RULE_14]
        assign suppress[i] = (sel_w[i] != sel_prev_ff[i]);

        eil_edge_detect #(
            .RESET_LEVEL(1'b1)
        ) u_edge (
            .hclk(hclk),
            .hresetn(hresetn),
            .edge_sel(sel_w[i]),
            .suppress(suppress[i]),
            .level(lvl[i]),
            .hit(hit[i])
        );
    end

    // ------------------------------------------------------------------
    // interrupt latches
    // ------------------------------------------------------------------
    // first latch blocked while its pin serves the port [RULE_04]
    always_comb begin
        gate = '1;
        gate[SRC_A] = first_sel;
    end

    // a plain load of zero clears; a one leaves the latch alone
    always_comb begin
        latch_clr = irq_ack;
        if (wr_data_phase && idx_ff == IDX_LATCH) begin
            latch_clr = latch_clr | ~hwdata[NUM_SRC-1:0];
        end
    end

    // a new edge wins over a clear in the same cycle [RULE_08]
    assign nxt_latch = (latch_ff & ~latch_clr) | (hit & gate);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_ff <= '0;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    // ------------------------------------------------------------------
    // requests and pin outputs
    // ------------------------------------------------------------------
    // software masks false requests from port output changes by enable [RULE_10]
    assign nxt_irq_request = {NUM_SRC{master_ff}} & enable_ff & latch_ff & gate; // [RULE_05]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_request_ff <= '0;
        end else begin
            irq_request_ff <= nxt_irq_request;
        end
    end

    // the timer sees the same cleaned level as the interrupt [RULE_09]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer1_ff <= 1'b1;
        end else begin
            timer1_ff <= lvl[SRC_B];
        end
    end

    // ------------------------------------------------------------------
    // shared port pin
    // ------------------------------------------------------------------
    logic port5_out_ff;
    logic port5_oe_ff;

    // interrupt use forces the pin to input [RULE_03]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port5_out_ff <= 1'b0;
            port5_oe_ff <= 1'b0;
        end else begin
            port5_out_ff <= port5_ff[PORT5_DATA];
            port5_oe_ff <= port5_ff[PORT5_DIR] & ~first_sel;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign irq_request = irq_request_ff;
    assign timer1_count_input = timer1_ff;
    assign port5_bit0_out = port5_out_ff;
    assign port5_bit0_oe = port5_oe_ff;
endmodule : eil_ext_irq_ctrl

/* sim/eil_ext_irq_ctrl_asserts.sv */
// Purpose: concurrent checks on the external interrupt input block
// Assumes: single word AHB-Lite transfers, pins synchronous to hclk
// Notes:   register shadows are rebuilt from observed bus writes
`timescale 1ns/1ps
module eil_ext_irq_ctrl_asserts import eil_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // pins and results
    input wire logic ext_irq_b,
    input wire logic [NUM_SRC-1:0] irq_request,
    input wire logic port5_bit0_oe,
    input wire logic timer1_count_input
);
    logic wr_ff;
    logic rd_ff;
    logic [7:0] idx_ff;
    logic [7:0] ctrl_ff;
    logic [4:0] en_ff;
    logic mst_ff;
    logic pin_ff;
    logic [4:0] run_ff;
    logic sel_a;
    logic arm_b;
    assign sel_a = ctrl_ff[CTRL_FIRST_SEL];
    assign arm_b = ctrl_ff[CTRL_SECOND_ES] && mst_ff && en_ff[SRC_B] && !pin_ff;
    // --------------------------------------------------------------
    // helper logic
    // --------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            idx_ff <= 8'h0;
        end else begin
            wr_ff <= hsel && htrans[1] && hready && hwrite;
            rd_ff <= hsel && htrans[1] && hready && !hwrite;
            idx_ff <= haddr[9:2];
        end
    end
    // shadows load at the data phase edge, the same edge as the registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= 8'h0;
            en_ff <= 5'h0;
            mst_ff <= 1'b0;
        end else if (wr_ff) begin
            if (idx_ff == IDX_CTRL) ctrl_ff <= hwdata[7:0];
            if (idx_ff == IDX_ENABLE) en_ff <= hwdata[4:0];
            if (idx_ff == IDX_MASTER) mst_ff <= hwdata[0];
        end
    end
    // saturates so a long steady level never wraps into a false match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_ff <= 1'b1;
            run_ff <= 5'h0;
        end else begin
            pin_ff <= ext_irq_b;
            if (ext_irq_b != pin_ff) run_ff <= 5'h1;
            else if (run_ff != 5'h1F) run_ff <= run_ff + 5'h1;
        end
    end
    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !hresetn |-> !port5_bit0_oe && irq_request == 5'h0) else $error("busy in reset");
    AST_OE_OFF: assert property (sel_a && $past(sel_a) |-> !port5_bit0_oe)
        else $error("port drives pin in interrupt mode");
    AST_A_NEEDS_FUNC: assert property (irq_request[SRC_A] |-> sel_a || $past(sel_a))
        else $error("first request without pin function");
    AST_NEEDS_MASTER: assert property (|irq_request |-> mst_ff || $past(mst_ff))
        else $error("request with master off");
    AST_NEEDS_ENABLE: assert property ((irq_request & ~(en_ff | $past(en_ff))) == 5'h0)
        else $error("request with source disabled");
    AST_MASTER_DROPS: assert property ($fell(mst_ff) |-> ##[0:2] irq_request == 5'h0)
        else $error("request outlives master");
    AST_B_LATCH_BOUND: assert property (run_ff == 5'h19 && arm_b
        |-> ##[0:6] irq_request[SRC_B]) else $error("second input late");
    AST_TIMER_FOLLOWS: assert property (run_ff == 5'h1A |-> timer1_count_input == pin_ff)
        else $error("timer input not filtered level");
    AST_CTRL_WO: assert property (rd_ff && idx_ff == IDX_CTRL |-> hrdata == RDATA_ZERO)
        else $error("control register readable");
    cover property (run_ff == 5'h19 && arm_b);
    cover property ($rose(irq_request[SRC_A]));
    cover property (rd_ff && idx_ff == IDX_CTRL);
endmodule : eil_ext_irq_ctrl_asserts

bind eil_ext_irq_ctrl eil_ext_irq_ctrl_asserts eil_ext_irq_ctrl_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .ext_irq_b(ext_irq_b), .irq_request(irq_request), .port5_bit0_oe(port5_bit0_oe),
    .timer1_count_input(timer1_count_input));

/* sim/eil_pin_src.sv */
// Purpose: off-chip signal sources for the five interrupt pins
// Assumes: sources change just after a clock edge
// Notes:   pins idle high as if pulled up; they move only when a test asks
`timescale 1ns/1ps
module eil_pin_src (
    // clock
    input wire logic hclk,
    // pins, bit 0 is the first input
    output logic [4:0] pins
);
    initial pins = 5'h1F;
    task automatic step(input int s, input logic lvl);
        @(posedge hclk);
        pins[s] <= lvl;
    endtask : step
    // width counts whole cycles at the driven level
    task automatic pulse(input int s, input int w, input logic lvl);
        step(s, lvl);
        repeat (w) @(posedge hclk);
        pins[s] <= ~lvl;
    endtask : pulse
endmodule : eil_pin_src

/* sim/external_irq_input_logic_tb.sv */
// Purpose: register and pin level test of the external interrupt block
// Assumes: zero wait state slave, fc equal to hclk
// Notes:   latch checks read the latch register over the bus
`timescale 1ns/1ps
module external_irq_input_logic_tb import eil_pkg::*;;
    logic hclk = 1'b0;
    // no initialiser: the drop from unknown to low at time zero must reach the async resets
    logic hresetn;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] rc_edge_sel = 2'h1;
    logic [4:0] irq_ack = 5'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [4:0] irq_request;
    logic port5_bit0_out;
    logic port5_bit0_oe;
    logic timer1_count_input;
    logic [4:0] pins;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] idx_list [6] = '{IDX_CTRL, IDX_LATCH, IDX_ENABLE, IDX_MASTER, IDX_PORT5, 8'h0};
    int sl [4] = '{SRC_A, SRC_E, SRC_B, SRC_D};
    int ws [4] = '{1, 1, 6, 6};
    int wl [4] = '{7, 7, 25, 25};
    logic [31:0] mk [4] = '{32'h1, 32'h10, 32'h2, 32'h8};

    always #5 hclk = ~hclk;

    eil_ext_irq_ctrl eil_ext_irq_ctrl_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_irq_a(pins[SRC_A]), .ext_irq_b(pins[SRC_B]), .ext_irq_c(pins[SRC_C]),
        .ext_irq_d(pins[SRC_D]), .ext_irq_e(pins[SRC_E]), .rc_edge_sel(rc_edge_sel),
        .irq_ack(irq_ack), .irq_request(irq_request), .port5_bit0_out(port5_bit0_out),
        .port5_bit0_oe(port5_bit0_oe), .timer1_count_input(timer1_count_input));

    eil_pin_src eil_pin_src_inst (.hclk(hclk), .pins(pins));

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // waits on hreadyout are cut short only by the cycle ceiling
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        ahb(1'b1, idx, wd, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, idx, 32'h0, rd);
        check(rd, exp);
        check(32'(hresp), 32'h0);
    endtask : rd_chk

    task automatic edges(input int s, input int w, input logic [31:0] ef, input logic [31:0] er);
        eil_pin_src_inst.step(s, 1'b0);
        repeat (w) @(posedge hclk);
        rd_chk(IDX_LATCH, ef);
        if (s == SRC_B) check(32'(timer1_count_input), 32'h0);
        wr(IDX_LATCH, 32'h0);
        eil_pin_src_inst.step(s, 1'b1);
        repeat (w) @(posedge hclk);
        rd_chk(IDX_LATCH, er);
        wr(IDX_LATCH, 32'h0);
    endtask : edges

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // --------------------------------------------------------------
    // sequence
    // --------------------------------------------------------------
    initial begin
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        foreach (idx_list[i]) rd_chk(idx_list[i], 32'h0);
        rd_chk(IDX_PINS, 32'h1F1F);
        check(32'(port5_bit0_oe), 32'h0);
        wr(IDX_PORT5, 32'h3);
        repeat (2) @(posedge hclk);
        check(32'({port5_bit0_oe, port5_bit0_out}), 32'h3);
        eil_pin_src_inst.pulse(SRC_A, 10, 1'b0);
        repeat (8) @(posedge hclk);
        rd_chk(IDX_LATCH, 32'h0);
        wr(IDX_CTRL, 32'h40);
        repeat (2) @(posedge hclk);
        check(32'(port5_bit0_oe), 32'h0);
        wr(IDX_PORT5, 32'h0);
        wr(IDX_ENABLE, 32'h1F);
        for (int es = 0; es < 2; es++) begin
            wr(IDX_MASTER, 32'h0);
            wr(IDX_CTRL, es ? 32'h54 : 32'h40);
            repeat (8) @(posedge hclk);
            wr(IDX_LATCH, 32'h0);
            wr(IDX_MASTER, 32'h1);
            edges(SRC_B, 29, es ? 32'h2 : 32'h0, es ? 32'h0 : 32'h2);
            edges(SRC_D, 29, es ? 32'h8 : 32'h0, es ? 32'h0 : 32'h8);
        end
        for (int i = 0; i < 4; i++) begin
            eil_pin_src_inst.pulse(sl[i], ws[i], 1'b0);
            repeat (20) @(posedge hclk);
            rd_chk(IDX_LATCH, 32'h0);
            eil_pin_src_inst.pulse(sl[i], wl[i], 1'b0);
            repeat (20) @(posedge hclk);
            rd_chk(IDX_LATCH, mk[i]);
            wr(IDX_LATCH, 32'h0);
        end
        edges(SRC_A, 10, 32'h1, 32'h0);
        edges(SRC_E, 10, 32'h10, 32'h0);
        for (int m = 0; m < 4; m++) begin
            rc_edge_sel <= 2'(m);
            repeat (8) @(posedge hclk);
            edges(SRC_C, 4, (m == 1 || m == 2) ? 32'h4 : 32'h0,
                  (m == 0 || m == 2) ? 32'h4 : 32'h0);
        end
        eil_pin_src_inst.pulse(SRC_A, 10, 1'b0);
        repeat (6) @(posedge hclk);
        check(32'(irq_request), 32'h1);
        wr(IDX_ENABLE, 32'h1E);
        repeat (2) @(posedge hclk);
        check(32'(irq_request), 32'h0);
        irq_ack <= 5'h1;
        @(posedge hclk);
        irq_ack <= 5'h0;
        repeat (2) @(posedge hclk);
        rd_chk(IDX_LATCH, 32'h0);
        tally_and_finish();
    end
endmodule : external_irq_input_logic_tb
